// file: tpdo_modbus_mapper.sv
// tpdo_modbus_mapper: one tpdo mapping entry. captures received frames under the
// inhibit time, and at each transfer point writes the mapped words to modbus storage.
// assumes frames and sync arrive as one-cycle pulses synchronous to clk_in, and that
// the modbus register file honours the write mask.

`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - communication object index is 0x1800 plus configured pdo index minus one.
// - mapped data is transferred into register storage once per trigger: period timer for asynchronous types, each sync, or every sync_factor-th sync.
// - transmission type comes out of reset as asynchronous.
// - sync factor, clamped 1..240, counts sync events only in synchronous cyclic mode.
// - frames closer together than the inhibit time are not accepted.
// - operation unit is bit, byte, word, double word or quad word.
// - double and quad words spread over consecutive register addresses from the base.
// - byte offset picks the starting byte within the eight-byte frame.
// - bit offset picks a bit in the addressed byte, used only for bit units.
// - each entry takes its data from a fixed constant or from the live frame.
// - fixed constants go out with the configured modbus byte order.
// - words assemble little-endian, byte 0 low; bit and byte zero-extend.
// - double word fills two registers from successive byte pairs.
// - register byte order on the modbus side follows the configured order.
module tpdo_modbus_mapper
	import tpdo_map_pkg::*;
#(
	parameter int CYCLES_PER_MS = CLK_PER_MS
)
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// configuration
	input  wire logic        cfg_load_in,
	input  wire map_cfg_t    cfg_in,
	// can side
	input  wire logic        frame_valid_in,
	input  wire logic [63:0] frame_data_in,
	input  wire logic        sync_in,
	// modbus storage side
	output reg_wr_t          reg_wr_out,
	// status
	output logic      [15:0] comm_index_out,
	output logic             frame_drop_out,
	output logic             xfer_done_out,
	output logic             busy_out
);

	localparam int PRE_W = $clog2(CYCLES_PER_MS);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);

	////////////////////////////////////////////////////////////////////////////
	// configuration and millisecond timebase

	map_cfg_t         cfg_q, cfg_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic             ms_tick_q, ms_tick_d;
	logic [15:0]      comm_index_q, comm_index_d;

	// the timebase runs free; timers built on it are therefore accurate to one ms
	always_comb
	begin
		cfg_d     = cfg_load_in ? cfg_in : cfg_q;
		ms_tick_d = (pre_q == PRE_LAST);
		pre_d     = ms_tick_d ? '0 : pre_q + PRE_W'(1);
		comm_index_d = TPDO_COMM_BASE + {8'h00, cfg_q.pdo_index} - PDO_INDEX_BIAS;
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			cfg_q        <= CFG_RESET;
			pre_q        <= '0;
			ms_tick_q    <= 1'b0;
			comm_index_q <= TPDO_COMM_BASE;
		end
		else
		begin
			cfg_q        <= cfg_d;
			pre_q        <= pre_d;
			ms_tick_q    <= ms_tick_d;
			comm_index_q <= comm_index_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame capture under the inhibit time

	logic [63:0] frame_q, frame_d;
	logic        have_frame_q, have_frame_d;
	logic [16:0] inh_cnt_q, inh_cnt_d;
	logic        drop_q, drop_d;
	logic        inh_ok;

	// the counter restarts on acceptance and the first tick may be partial,
	// so strictly more ticks than the setting are needed; one bit wider than
	// the setting so that 65535 can still expire before saturation
	always_comb
	begin
		inh_ok = (cfg_q.inhibit_ms == 16'h0000) ||
			(inh_cnt_q > {1'b0, cfg_q.inhibit_ms});
		frame_d      = frame_q;
		have_frame_d = have_frame_q;
		drop_d       = 1'b0;
		inh_cnt_d    = inh_cnt_q;
		if (ms_tick_q && !(&inh_cnt_q))
			inh_cnt_d = inh_cnt_q + 17'h00001;
		if (frame_valid_in)
		begin
			if (inh_ok)
			begin
				frame_d      = frame_data_in;
				have_frame_d = 1'b1;
				inh_cnt_d    = 17'h00000;
			end
			else
				drop_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			frame_q      <= 64'h0;
			have_frame_q <= 1'b0;
			inh_cnt_q    <= 17'h1ffff;
			drop_q       <= 1'b0;
		end
		else
		begin
			frame_q      <= frame_d;
			have_frame_q <= have_frame_d;
			inh_cnt_q    <= inh_cnt_d;
			drop_q       <= drop_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transfer trigger: period for asynchronous types, sync events otherwise

	logic [15:0] per_cnt_q, per_cnt_d;
	logic [7:0]  sync_cnt_q, sync_cnt_d;
	logic [7:0]  eff_factor;
	logic        trig;

	always_comb
	begin
		// factor outside 1..240 is pulled to the nearest limit
		if (cfg_q.sync_factor < SYNC_FACTOR_MIN)
			eff_factor = SYNC_FACTOR_MIN;
		else if (cfg_q.sync_factor > SYNC_FACTOR_MAX)
			eff_factor = SYNC_FACTOR_MAX;
		else
			eff_factor = cfg_q.sync_factor;
		trig       = 1'b0;
		per_cnt_d  = per_cnt_q;
		sync_cnt_d = sync_cnt_q;
		unique case (cfg_q.tx_type)
			TT_SYNC_CYC:
			begin
				if (sync_in)
				begin
					trig       = (sync_cnt_q + 8'h01 >= eff_factor);
					sync_cnt_d = trig ? 8'h00 : sync_cnt_q + 8'h01;
				end
			end
			TT_SYNC_ACYC:
				trig = sync_in;
			default:
			begin
				if (ms_tick_q)
				begin
					trig      = (per_cnt_q + 16'h0001 >= cfg_q.period_ms);
					per_cnt_d = trig ? 16'h0000 : per_cnt_q + 16'h0001;
				end
			end
		endcase
		// a new configuration restarts both counters
		if (cfg_load_in)
		begin
			per_cnt_d  = 16'h0000;
			sync_cnt_d = 8'h00;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			per_cnt_q  <= 16'h0000;
			sync_cnt_q <= 8'h00;
		end
		else
		begin
			per_cnt_q  <= per_cnt_d;
			sync_cnt_q <= sync_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write sequencer

	seq_state_t  state_q, state_d;
	logic [63:0] src_q, src_d;
	logic [1:0]  word_q, word_d;
	logic        pend_q, pend_d;
	reg_wr_t     wr_q, wr_d;
	logic        done_q, done_d;
	logic        busy_q, busy_d;
	logic [2:0]  n_words;
	logic        src_ready;
	logic [15:0] bld_data;
	logic [15:0] bld_mask;

	tpdo_word_builder u_builder
	(
		.src_in      (src_q),
		.unit_in     (cfg_q.unit),
		.byte_off_in (cfg_q.byte_off),
		.bit_off_in  (cfg_q.bit_off),
		.swap_in     (cfg_q.swap_bytes),
		.word_idx_in (word_q),
		.data_out    (bld_data),
		.mask_out    (bld_mask)
	);

	// the source is snapshotted at start so a frame landing mid-sequence
	// cannot tear a multi-register value
	always_comb
	begin
		unique case (cfg_q.unit)
			UNIT_DWORD: n_words = WORDS_DWORD;
			UNIT_QWORD: n_words = WORDS_QWORD;
			default:    n_words = WORDS_SINGLE;
		endcase
		src_ready = cfg_q.src_fixed || have_frame_q;
		state_d   = state_q;
		src_d     = src_q;
		word_d    = word_q;
		pend_d    = pend_q | trig;
		wr_d      = '0;
		done_d    = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				if ((trig || pend_q) && src_ready)
				begin
					src_d   = cfg_q.src_fixed ? cfg_q.fixed_val : frame_q;
					word_d  = 2'h0;
					pend_d  = 1'b0;
					state_d = ST_WRITE;
				end
				else if (!src_ready)
					pend_d = 1'b0; // nothing to map yet
			end
			ST_WRITE:
			begin
				wr_d.wr   = 1'b1;
				wr_d.addr = cfg_q.reg_addr + {14'h0000, word_q};
				wr_d.data = bld_data;
				wr_d.mask = bld_mask;
				word_d    = word_q + 2'h1;
				if ({1'b0, word_q} + 3'h1 >= n_words)
					state_d = ST_DONE;
			end
			ST_DONE:
			begin
				done_d  = 1'b1;
				state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			state_q <= ST_IDLE;
			src_q   <= 64'h0;
			word_q  <= 2'h0;
			pend_q  <= 1'b0;
			wr_q    <= '0;
			done_q  <= 1'b0;
			busy_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			src_q   <= src_d;
			word_q  <= word_d;
			pend_q  <= pend_d;
			wr_q    <= wr_d;
			done_q  <= done_d;
			busy_q  <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign reg_wr_out     = wr_q;
	assign comm_index_out = comm_index_q;
	assign frame_drop_out = drop_q;
	assign xfer_done_out  = done_q;
	assign busy_out       = busy_q;

endmodule // tpdo_modbus_mapper

`default_nettype wire

// file: tpdo_map_pkg.sv
// tpdo_map_pkg: constants and types shared by the tpdo to modbus mapper.
// assumes a single 25 MHz clock domain and one mapping entry per mapper instance.

`default_nettype none

package tpdo_map_pkg;

	// communication parameter object base index
	localparam logic [15:0] TPDO_COMM_BASE = 16'h1800;
	localparam logic [15:0] PDO_INDEX_BIAS = 16'h0001;

	// timing: one millisecond expressed in clock cycles (exact, 25000)
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS         = 1000000;
	localparam int CLK_PER_MS    = MS_NS / CLK_PERIOD_NS;

	// synchronisation factor limits
	localparam logic [7:0] SYNC_FACTOR_MIN = 8'h01;
	localparam logic [7:0] SYNC_FACTOR_MAX = 8'hf0;

	// frame layout and write masks
	localparam int          FRAME_BYTES = 8;
	localparam logic [15:0] MASK_BIT    = 16'h0001;
	localparam logic [15:0] MASK_FULL   = 16'hffff;

	// register words per operation unit
	localparam logic [2:0] WORDS_SINGLE = 3'h1;
	localparam logic [2:0] WORDS_DWORD  = 3'h2;
	localparam logic [2:0] WORDS_QWORD  = 3'h4;

	typedef enum logic [2:0]
	{
		UNIT_BIT   = 3'h0,
		UNIT_BYTE  = 3'h1,
		UNIT_WORD  = 3'h2,
		UNIT_DWORD = 3'h3,
		UNIT_QWORD = 3'h4
	} op_unit_t;

	typedef enum logic [1:0]
	{
		TT_SYNC_ACYC  = 2'h0,
		TT_SYNC_CYC   = 2'h1,
		TT_ASYNC_MFR  = 2'h2,
		TT_ASYNC_PROF = 2'h3
	} tx_type_t;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_DONE  = 2'b11
	} seq_state_t;

	typedef struct packed
	{
		logic [7:0]  pdo_index;
		tx_type_t    tx_type;
		logic [7:0]  sync_factor;
		logic [15:0] inhibit_ms;
		logic [15:0] period_ms;
		op_unit_t    unit;
		logic [2:0]  byte_off;
		logic [2:0]  bit_off;
		logic        src_fixed;
		logic        swap_bytes;
		logic [15:0] reg_addr;
		logic [63:0] fixed_val;
	} map_cfg_t;

	localparam map_cfg_t CFG_RESET = '{
		pdo_index:   8'h01,
		tx_type:     TT_ASYNC_PROF,
		sync_factor: 8'h01,
		inhibit_ms:  16'h0000,
		period_ms:   16'h03e8,
		unit:        UNIT_WORD,
		byte_off:    3'h0,
		bit_off:     3'h0,
		src_fixed:   1'b0,
		swap_bytes:  1'b0,
		reg_addr:    16'h0000,
		fixed_val:   64'h0
	};

	typedef struct packed
	{
		logic        wr;
		logic [15:0] addr;
		logic [15:0] data;
		logic [15:0] mask;
	} reg_wr_t;

endpackage

`default_nettype wire

// file: tpdo_word_builder.sv
// tpdo_word_builder: builds one 16-bit modbus register word and its write mask
// from an eight-byte source. purely combinational; the caller registers the result.

`timescale 1ns/100ps
`default_nettype none

module tpdo_word_builder
	import tpdo_map_pkg::*;
(
	// source bytes, byte 0 in bits 7:0
	input  wire logic [63:0] src_in,
	// entry layout
	input  wire op_unit_t    unit_in,
	input  wire logic [2:0]  byte_off_in,
	input  wire logic [2:0]  bit_off_in,
	input  wire logic        swap_in,
	input  wire logic [1:0]  word_idx_in,
	// result
	output logic      [15:0] data_out,
	output logic      [15:0] mask_out
);

	logic [7:0] src_bytes [FRAME_BYTES];
	logic [3:0] lo_idx;
	logic [3:0] hi_idx;
	logic [7:0] lo_byte;
	logic [7:0] hi_byte;
	logic [15:0] raw_data;
	logic [15:0] raw_mask;

	// unpack the frame into bytes
	for (genvar i = 0; i < FRAME_BYTES; i++)
	begin : g_bytes
		assign src_bytes[i] = src_in[8*i +: 8];
	end

	// little-endian pick: lower byte at offset + 2*word, upper byte right after it
	always_comb
	begin
		lo_idx  = {1'b0, byte_off_in} + {1'b0, word_idx_in, 1'b0};
		hi_idx  = lo_idx + 4'h1;
		// bytes past the end of the frame read as zero rather than wrapping
		lo_byte = lo_idx[3] ? 8'h00 : src_bytes[lo_idx[2:0]];
		hi_byte = hi_idx[3] ? 8'h00 : src_bytes[hi_idx[2:0]];
		unique case (unit_in)
			UNIT_BIT:
			begin
				raw_data = {15'h0000, lo_byte[bit_off_in]};
				raw_mask = MASK_BIT;
			end
			UNIT_BYTE:
			begin
				raw_data = {8'h00, lo_byte};
				raw_mask = MASK_FULL;
			end
			default:
			begin
				raw_data = {hi_byte, lo_byte};
				raw_mask = MASK_FULL;
			end
		endcase
		// modbus side byte order, mask follows the data lanes
		data_out = swap_in ? {raw_data[7:0], raw_data[15:8]} : raw_data;
		mask_out = swap_in ? {raw_mask[7:0], raw_mask[15:8]} : raw_mask;
	end

endmodule // tpdo_word_builder

`default_nettype wire

// file: can_slave_model.sv
// can_slave_model: behavioural canopen slave that puts tpdo frames on the can side.
// assumes the bench asks for each frame with a one-cycle send request.
`timescale 1ns/100ps
`default_nettype none
module can_slave_model
(
	// bench side
	input  wire logic        clk_in,
	input  wire logic        send_in,
	input  wire logic [63:0] bytes_in,
	// mapper side
	output var  logic        frame_valid_out,
	output var  logic [63:0] frame_data_out
);
	initial frame_valid_out = 1'b0;
	initial frame_data_out = 64'h0;
	// data lines flip between frames so stale bytes never pass for a frame
	always @(posedge clk_in)
	begin
		frame_valid_out <= send_in;
		frame_data_out  <= send_in ? bytes_in : ~frame_data_out;
	end
endmodule // can_slave_model
`default_nettype wire

// file: tpdo_map_checker.sv
// tpdo_map_checker: timing and framing checks on the mapper's ports.
// assumes the bench holds cfg_in steady between loads.
`timescale 1ns/100ps
`default_nettype none
module tpdo_map_checker
	import tpdo_map_pkg::*;
#(
	parameter int CYCLES_PER_MS = CLK_PER_MS
)
(
	// clock and reset
	input wire logic        clk_in,
	input wire logic        nrst_in,
	// inputs seen
	input wire logic        cfg_load_in,
	input wire map_cfg_t    cfg_in,
	input wire logic        frame_valid_in,
	input wire logic [63:0] frame_data_in,
	input wire logic        sync_in,
	// outputs seen
	input wire reg_wr_t     reg_wr_out,
	input wire logic [15:0] comm_index_out,
	input wire logic        frame_drop_out,
	input wire logic        xfer_done_out,
	input wire logic        busy_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////////////////////
	// sequencing and data shape
	chk_index_value: assert property ($past(cfg_load_in, 2) |->
		comm_index_out == 16'h17ff + $past(cfg_in.pdo_index, 2)) else $error("index wrong");
	chk_busy_write: assert property ($rose(busy_out) |=> reg_wr_out.wr)
		else $error("no write after busy");
	chk_done_end: assert property (xfer_done_out |-> !busy_out && $past(reg_wr_out.wr))
		else $error("done misplaced");
	chk_mask_legal: assert property (reg_wr_out.wr |->
		reg_wr_out.mask inside {16'hffff, 16'h0001, 16'h0100}) else $error("bad mask");
	chk_addr_step: assert property (reg_wr_out.wr && $past(reg_wr_out.wr) |->
		reg_wr_out.addr == $past(reg_wr_out.addr) + 16'h0001) else $error("addr step");
	chk_drop_cause: assert property (frame_drop_out |-> $past(frame_valid_in))
		else $error("drop without frame");
	// fixed source never lacks data, so an acyclic sync always writes
	chk_sync_start: assert property (sync_in && !busy_out && !xfer_done_out &&
		!cfg_load_in && !$past(cfg_load_in) && cfg_in.src_fixed &&
		cfg_in.tx_type == TT_SYNC_ACYC |-> ##2 reg_wr_out.wr) else $error("no sync write");
	chk_bit_only: assert property (reg_wr_out.wr && cfg_in.unit == UNIT_BIT &&
		!cfg_in.swap_bytes |-> reg_wr_out.mask == 16'h0001 && reg_wr_out.data[15:1] == 0)
		else $error("bit write wide");
endmodule // tpdo_map_checker
bind tpdo_modbus_mapper tpdo_map_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
	.clk_in(clk_in), .nrst_in(nrst_in), .cfg_load_in(cfg_load_in), .cfg_in(cfg_in),
	.frame_valid_in(frame_valid_in), .frame_data_in(frame_data_in), .sync_in(sync_in),
	.reg_wr_out(reg_wr_out), .comm_index_out(comm_index_out),
	.frame_drop_out(frame_drop_out), .xfer_done_out(xfer_done_out), .busy_out(busy_out));
`default_nettype wire

// file: tpdo_modbus_mapper_tb.sv
// tpdo_modbus_mapper_tb: self-checking bench for one tpdo mapping entry.
// assumes the checker is bound in; a millisecond is shortened to 10 cycles.
`timescale 1ns/100ps
`default_nettype none
module tpdo_modbus_mapper_tb;
	import tpdo_map_pkg::*;
	typedef struct packed {op_unit_t u; logic [2:0] bo; logic [2:0] bi; logic sw; logic fx;
		logic [63:0] ex; logic [15:0] mk;} row_t;
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic        cfg_load_in = 1'b0;
	logic        sync_in = 1'b0;
	logic        send_req = 1'b0;
	logic [63:0] frame_bytes = 64'h0;
	map_cfg_t    cfg_in = CFG_RESET;
	map_cfg_t    c;
	logic        frame_valid_in;
	logic [63:0] frame_data_in;
	reg_wr_t     reg_wr_out;
	logic [15:0] comm_index_out;
	logic        frame_drop_out;
	logic        xfer_done_out;
	logic        busy_out;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          drops = 0;
	int          nw;
	int          n;
	// live frame is 01..08; fixed constant is cafe_beef
	row_t rows[11] = '{
		'{UNIT_WORD, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0201, 16'hffff},
		'{UNIT_BYTE, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0001, 16'hffff},
		'{UNIT_BIT, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0001, 16'h0001},
		'{UNIT_DWORD, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0403_0201, 16'hffff},
		'{UNIT_QWORD, 3'h0, 3'h0, 1'b0, 1'b0, 64'h0807_0605_0403_0201, 16'hffff},
		'{UNIT_WORD, 3'h3, 3'h0, 1'b0, 1'b0, 64'h0504, 16'hffff},
		'{UNIT_BIT, 3'h2, 3'h1, 1'b0, 1'b0, 64'h0001, 16'h0001},
		'{UNIT_WORD, 3'h0, 3'h0, 1'b1, 1'b0, 64'h0102, 16'hffff},
		'{UNIT_BIT, 3'h0, 3'h0, 1'b1, 1'b0, 64'h0100, 16'h0100},
		'{UNIT_WORD, 3'h0, 3'h0, 1'b1, 1'b1, 64'hefbe, 16'hffff},
		'{UNIT_DWORD, 3'h0, 3'h0, 1'b0, 1'b1, 64'hcafe_beef, 16'hffff}};
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) if (frame_drop_out === 1'b1) drops++;
	////////////////////////////////////////////////////////////////////////////////
	tpdo_modbus_mapper #(.CYCLES_PER_MS(10)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.cfg_load_in(cfg_load_in), .cfg_in(cfg_in), .frame_valid_in(frame_valid_in),
		.frame_data_in(frame_data_in), .sync_in(sync_in), .reg_wr_out(reg_wr_out),
		.comm_index_out(comm_index_out), .frame_drop_out(frame_drop_out),
		.xfer_done_out(xfer_done_out), .busy_out(busy_out));
	can_slave_model slave (.clk_in(clk_in), .send_in(send_req), .bytes_in(frame_bytes),
		.frame_valid_out(frame_valid_in), .frame_data_out(frame_data_in));
	////////////////////////////////////////////////////////////////////////////////
	// inputs move 1 ns after the rising edge so sampling never races
	task automatic tick(int k = 1);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
			num_errors++;
		end
	endtask
	task automatic load(map_cfg_t v);
		cfg_in = v;
		cfg_load_in = 1'b1;
		tick();
		cfg_load_in = 1'b0;
		tick(3);
	endtask
	task automatic send(logic [63:0] b);
		frame_bytes = b;
		send_req = 1'b1;
		tick();
		send_req = 1'b0;
		tick();
	endtask
	task automatic pulse_sync();
		sync_in = 1'b1;
		tick();
		sync_in = 1'b0;
	endtask
	task automatic wait_wr();
		int t;
		t = 0;
		while (reg_wr_out.wr !== 1'b1 && t < 100)
		begin
			tick();
			t++;
		end
		// a write that shows up on the very last try still counts as seen
		if (reg_wr_out.wr !== 1'b1)
		begin
			num_errors++;
			end_sim();
		end
	endtask
	// sync cyclic: only the e-th sync after a load may write
	task automatic cyc(logic [7:0] f, int e);
		map_cfg_t k;
		k = CFG_RESET;
		k.tx_type = TT_SYNC_CYC;
		k.sync_factor = f;
		load(k);
		for (int s = 1; s <= e; s++)
		begin
			pulse_sync();
			// the write stands for one cycle, one edge after the sync edge
			tick();
			chk("wr", reg_wr_out.wr, s == e);
			tick(4);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		tick();
		chk("index", comm_index_out, 16'h1800);
		send(64'h0807060504030201);
		pulse_sync();
		tick(5);
		chk("busy", busy_out, 0);
		c = CFG_RESET;
		c.pdo_index = 8'h05;
		load(c);
		chk("index", comm_index_out, 16'h1804);
		$display("reset test done");
		foreach (rows[i])
		begin
			c = CFG_RESET;
			c.tx_type = TT_SYNC_ACYC;
			c.unit = rows[i].u;
			c.byte_off = rows[i].bo;
			c.bit_off = rows[i].bi;
			c.swap_bytes = rows[i].sw;
			c.src_fixed = rows[i].fx;
			c.reg_addr = 16'h0100;
			c.fixed_val = 64'hcafe_beef;
			load(c);
			nw = (c.unit == UNIT_DWORD) ? 2 : (c.unit == UNIT_QWORD) ? 4 : 1;
			pulse_sync();
			wait_wr();
			for (int k = 0; k < nw; k++)
			begin
				chk("addr", reg_wr_out.addr, 16'h0100 + k);
				chk("data", reg_wr_out.data, rows[i].ex[16*k +: 16]);
				chk("mask", reg_wr_out.mask, rows[i].mk);
				tick();
			end
			chk("done", xfer_done_out, 1);
		end
		$display("row tests done");
		cyc(8'h03, 3);
		cyc(8'h00, 1);
		cyc(8'hfa, 240);
		$display("sync factor test done");
		c = CFG_RESET;
		c.tx_type = TT_SYNC_ACYC;
		c.inhibit_ms = 16'h0002;
		load(c);
		send(64'h1111);
		send(64'h2222);
		tick(3);
		chk("drops", drops, 1);
		pulse_sync();
		wait_wr();
		chk("data", reg_wr_out.data, 16'h1111);
		tick(40);
		send(64'h3333);
		tick(3);
		chk("drops", drops, 1);
		pulse_sync();
		wait_wr();
		chk("data", reg_wr_out.data, 16'h3333);
		$display("inhibit test done");
		c = CFG_RESET;
		c.period_ms = 16'h0002;
		load(c);
		n = 0;
		while (xfer_done_out !== 1'b1 && n < 100)
		begin
			tick();
			n++;
		end
		if (xfer_done_out !== 1'b1)
		begin
			num_errors++;
			end_sim();
		end
		tick();
		n = 1;
		while (xfer_done_out !== 1'b1 && n < 100)
		begin
			tick();
			n++;
		end
		chk("period", n, 20);
		if (xfer_done_out !== 1'b1)
		begin
			num_errors++;
			end_sim();
		end
		$display("period test done");
		// reset just as a quad word sequence starts, before its first write, must abort it cleanly
		c = CFG_RESET;
		c.tx_type = TT_SYNC_ACYC;
		c.unit = UNIT_QWORD;
		c.pdo_index = 8'h09;
		load(c);
		chk("index", comm_index_out, 16'h1808);
		pulse_sync();
		nrst_in = 1'b0;
		tick(2);
		nrst_in = 1'b1;
		tick();
		chk("rst wr", reg_wr_out, '0);
		chk("rst busy", busy_out, 0);
		chk("rst done", xfer_done_out, 0);
		chk("rst index", comm_index_out, 16'h1800);
		$display("mid reset test done");
		end_sim();
	end
endmodule // tpdo_modbus_mapper_tb
`default_nettype wire
